//--- verilog/scc_pkg.sv
// scc_pkg: shared constants and types for the standby and clock control block
// assumes a single 200 MHz system clock that also stands in for the main clock
package scc_pkg;

   // ==========================================================
   // register addresses (16-bit special function space)
   localparam logic [15:0] SCC_ADDR_STBY = 16'hffc0; // standby_control
   localparam logic [15:0] SCC_ADDR_CSTAT = 16'hffce; // clock_status
   localparam logic [15:0] SCC_ADDR_OSC_SETTLE_SELECT = 16'hffcf; // osc_settle_select

   // ==========================================================
   // reset values
   localparam logic [7:0] SCC_RST_STBY = 8'h30;
   localparam logic [7:0] SCC_RST_CSTAT = 8'h32;
   localparam logic [7:0] SCC_RST_OSC_SETTLE_SELECT = 8'h00;

   // ==========================================================
   // standby_control fields
   localparam int SCC_B_SUB_OSC_STOP = 7;
   localparam int SCC_B_CK_HI = 6;
   localparam int SCC_B_CK_MID = 5;
   localparam int SCC_B_CK_LO = 4;
   localparam int SCC_B_ZERO = 3; // always reads zero
   localparam int SCC_B_MAIN_OSC_STOP = 2;
   localparam int SCC_B_STOP_REQ = 1;
   localparam int SCC_B_HALT_REQ = 0;
   localparam logic [7:0] SCC_STBY_WMASK = 8'hf7;
   // clock_status fields not mirrored
   localparam int SCC_B_ONE = 1; // fixed one
   localparam int SCC_B_CPU_SRC = 0;
   // osc_settle_select fields
   localparam int SCC_B_EXT_CLK = 7;
   localparam logic [7:0] SCC_OSC_SETTLE_SELECT_WMASK = 8'h87;

   // ==========================================================
   // mode request codes
   localparam logic [1:0] SCC_REQ_NORMAL = 2'b00;
   localparam logic [1:0] SCC_REQ_HALT = 2'b01;
   localparam logic [1:0] SCC_REQ_STOP = 2'b10;
   localparam logic [1:0] SCC_REQ_IDLE = 2'b11;

   // ==========================================================
   // settle counts in main clock cycles
   localparam int SCC_SETTLE_LOG_MAX = 19; // longest wait is 2**19 cycles
   localparam int SCC_SETTLE_EXT_CYC = 512; // wait with external clock

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      SCC_RUN = 3'b000,
      SCC_HALT = 3'b001,
      SCC_MACRO = 3'b010,
      SCC_STOP = 3'b011,
      SCC_SETTLE = 3'b100,
      SCC_IDLE = 3'b101
   } scc_mode_t;

   // guarded immediate write to standby_control
   typedef struct packed {
      logic valid; // one-cycle instruction strobe
      logic [7:0] op3; // third opcode byte
      logic [7:0] op4; // fourth opcode byte
      logic [7:0] data; // immediate byte
      logic [19:0] pc; // address of the instruction
   } scc_gwr_t;

   // ordinary data write
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [7:0] data;
   } scc_wr_t;

endpackage : scc_pkg

//--- verilog/scc_clkdiv.sv
// scc_clkdiv: free running divider giving main clock enable pulses /1 /2 /4 /8
// assumes the caller registers the pulse before it leaves the block
`timescale 1ns/1ps
module scc_clkdiv (
   input logic clk, // system clock
   input logic rst_n, // async reset, active low
   input logic [1:0] sel, // divide select, log2 of ratio
   output logic tick // one-cycle enable pulse
);
   import scc_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      logic [2:0] cnt; // free running count
   } scc_div_state_t;

   scc_div_state_t r; // registered state
   scc_div_state_t next_r; // next state
   logic [2:0] mask; // low bits that must all be one

   // next count, wraps freely
   always_comb begin
      next_r = r;
      next_r.cnt = r.cnt + 3'h1;
   end

   // pulse when the selected low bits are all one
   always_comb begin
      mask = 3'(({1'b0, 3'h1} << sel) - 4'h1);
      tick = ((r.cnt & mask) == mask);
   end

   // register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule : scc_clkdiv

//--- verilog/scc_settle.sv
// scc_settle: oscillator settle timer started on leaving the stop mode
// assumes start is a one-cycle pulse and the clock is the main clock
`timescale 1ns/1ps
module scc_settle #(
   parameter int LOG_MAX = scc_pkg::SCC_SETTLE_LOG_MAX, // log2 of longest wait
   parameter int EXT_CYC = scc_pkg::SCC_SETTLE_EXT_CYC // wait with external clock
) (
   input logic clk, // system clock
   input logic rst_n, // async reset, active low
   input logic start, // begin a wait
   input logic ext, // external clock selected
   input logic [2:0] code, // settle time code
   output logic busy, // wait in progress
   output logic done // one-cycle pulse at expiry
);
   import scc_pkg::*;

   localparam int CW = LOG_MAX + 1; // counter width

   // refuse widths that cannot hold the shortest or external wait
   if (LOG_MAX < 8 || LOG_MAX > 30 || EXT_CYC < 1 || EXT_CYC >= (1 << CW)) begin : g_chk
      $error("scc_settle: unsupported LOG_MAX or EXT_CYC");
   end

   // ==========================================================
   // state
   typedef struct packed {
      logic busy; // counting
      logic done; // expiry pulse
      logic [CW-1:0] cnt; // cycles left minus one
   } scc_set_state_t;

   scc_set_state_t r; // registered state
   scc_set_state_t next_r; // next state
   logic [CW-1:0] target; // cycles to wait

   // pick the wait: 2**(LOG_MAX-code) or the fixed external figure
   always_comb begin
      if (ext) begin
         target = CW'(EXT_CYC);
      end else begin
         target = CW'({{(CW-1){1'b0}}, 1'b1} << (CW'(LOG_MAX) - CW'(code)));
      end
   end

   // load, count down, pulse once at zero
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      if (start) begin
         next_r.busy = 1'b1;
         next_r.cnt = target - CW'(1);
      end else if (r.busy) begin
         if (r.cnt == '0) begin
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
         end else begin
            next_r.cnt = r.cnt - CW'(1);
         end
      end
   end

   assign busy = r.busy;
   assign done = r.done;

   // register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule : scc_settle

//--- verilog/scc_top.sv
// scc_top: standby modes, cpu clock selection and oscillator control
// assumes the cpu core presents decoded write strobes and a read address each cycle
`timescale 1ns/1ps
module scc_top #(
   parameter int SETTLE_LOG_MAX = scc_pkg::SCC_SETTLE_LOG_MAX // longest settle wait, log2
) (
   input logic SYS_CLK, // 200 MHz system clock
   input logic NRST, // async reset, active low
   input scc_pkg::scc_gwr_t GWR, // guarded immediate write
   input scc_pkg::scc_wr_t WR, // ordinary data write
   input logic [15:0] RD_ADDR, // read address, sampled each cycle
   input logic NMI_PIN, // external non-maskable request
   input logic IRQ_UNMASKED, // any unmasked maskable request
   input logic MACRO_REQ, // unmasked macro service request
   input logic MACRO_DONE, // macro service finished, no vectored irq
   input logic SUB_TICK, // subsystem clock enable pulse
   output logic [7:0] RD_DATA, // read data, one cycle after address
   output logic CPU_TICK, // cpu clock enable pulse
   output logic CPU_ON_SUB, // cpu runs from subsystem clock
   output logic SYS_ACTIVE, // peripherals clocked
   output logic MAIN_OSC_RUN, // main oscillator enabled
   output logic XTAL_AMP_EN, // on-chip resonator amplifier enabled
   output logic SUB_OSC_RUN, // sub oscillator and feedback resistor on
   output logic OPERR_IRQ, // operand error pulse
   output logic [19:0] OPERR_PC, // return address for operand error
   output scc_pkg::scc_mode_t MODE // current operating state
);
   import scc_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      scc_mode_t mode; // operating state
      logic [7:0] stby; // standby_control
      logic [7:0] osc_settle_select; // osc_settle_select
      logic [7:0] rd; // read data
      logic tick; // cpu enable pulse
      logic on_sub; // cpu source
      logic active; // peripheral clock on
      logic main_run; // main osc enable
      logic xtal; // amplifier enable
      logic sub_run; // sub osc enable
      logic operr; // operand error pulse
      logic [19:0] pc; // saved return address
      logic settle_go; // start settle timer
   } scc_top_state_t;

   scc_top_state_t r; // registered state
   scc_top_state_t next_r; // next state
   logic div_tick; // main clock divided enable
   logic settle_busy; // settle timer running
   logic settle_done; // settle timer expired
   logic wake; // a valid release source
   logic guard_ok; // opcode bytes complementary
   logic [7:0] cstat; // clock_status view

   // ==========================================================
   // helpers
   scc_clkdiv u_div (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .sel(r.stby[SCC_B_CK_MID:SCC_B_CK_LO]),
      .tick(div_tick)
   );

   scc_settle #(
      .LOG_MAX(SETTLE_LOG_MAX),
      .EXT_CYC(SCC_SETTLE_EXT_CYC)
   ) u_settle (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .start(r.settle_go),
      .ext(r.osc_settle_select[SCC_B_EXT_CLK]),
      .code(r.osc_settle_select[2:0]),
      .busy(settle_busy),
      .done(settle_done)
   );

   // release sources; the watchdog has no path here on purpose
   assign wake = NMI_PIN | IRQ_UNMASKED;
   assign guard_ok = (GWR.op3 == ~GWR.op4);

   // status view: mirrored bits, fixed one, source flag
   always_comb begin
      cstat = r.stby & 8'hf4;
      cstat[SCC_B_ONE] = 1'b1;
      cstat[SCC_B_CPU_SRC] = r.on_sub;
   end

   // ==========================================================
   // next state
   always_comb begin
      next_r = r;
      next_r.operr = 1'b0;
      next_r.settle_go = 1'b0;
      case (r.mode)
         SCC_RUN: begin
            // writes only arrive while the cpu executes
            if (GWR.valid && guard_ok) begin
               next_r.stby = GWR.data & SCC_STBY_WMASK;
            end else if (GWR.valid) begin
               next_r.operr = 1'b1;
               next_r.pc = GWR.pc;
            end
            // plain writes to the control register fall through untouched
            if (WR.valid && WR.addr == SCC_ADDR_OSC_SETTLE_SELECT) begin
               next_r.osc_settle_select = WR.data & SCC_OSC_SETTLE_SELECT_WMASK;
            end
            // enter the requested mode, or drop it if an interrupt is waiting
            if (r.stby[1:0] != SCC_REQ_NORMAL) begin
               if (wake) begin
                  next_r.stby[1:0] = SCC_REQ_NORMAL;
               end else begin
                  case (r.stby[1:0])
                     SCC_REQ_HALT: next_r.mode = SCC_HALT;
                     SCC_REQ_STOP: next_r.mode = SCC_STOP;
                     default: next_r.mode = SCC_IDLE;
                  endcase
               end
            end
         end
         SCC_HALT: begin
            if (wake) begin
               next_r.mode = SCC_RUN;
               next_r.stby[1:0] = SCC_REQ_NORMAL;
            end else if (MACRO_REQ) begin
               next_r.mode = SCC_MACRO;
            end
         end
         SCC_MACRO: begin
            // service runs on the cpu clock, then back to halt
            if (MACRO_DONE) begin
               next_r.mode = SCC_HALT;
            end
         end
         SCC_STOP: begin
            if (wake) begin
               next_r.mode = SCC_SETTLE;
               next_r.settle_go = 1'b1;
               next_r.stby[1:0] = SCC_REQ_NORMAL;
            end
         end
         SCC_SETTLE: begin
            // cpu stays gated until the oscillator has settled
            if (settle_done) begin
               next_r.mode = SCC_RUN;
            end
         end
         SCC_IDLE: begin
            if (wake) begin
               next_r.mode = SCC_RUN;
               next_r.stby[1:0] = SCC_REQ_NORMAL;
            end
         end
         default: begin
            next_r.mode = SCC_RUN;
         end
      endcase

      // clock and oscillator controls follow the next state
      next_r.on_sub = next_r.stby[SCC_B_CK_HI];
      next_r.sub_run = ~next_r.stby[SCC_B_SUB_OSC_STOP];
      // stop bit only bites when the cpu is on the subsystem clock
      next_r.main_run = (next_r.mode != SCC_STOP) &&
         !(next_r.stby[SCC_B_CK_HI] && next_r.stby[SCC_B_MAIN_OSC_STOP]);
      next_r.xtal = next_r.main_run && !next_r.osc_settle_select[SCC_B_EXT_CLK];
      next_r.active = (next_r.mode == SCC_RUN) || (next_r.mode == SCC_HALT) ||
         (next_r.mode == SCC_MACRO);
      // cpu enable only while executing; subsystem or divided main clock
      if ((r.mode == SCC_RUN || r.mode == SCC_MACRO) && (next_r.mode == r.mode)) begin
         next_r.tick = r.stby[SCC_B_CK_HI] ? SUB_TICK : div_tick;
      end else begin
         next_r.tick = 1'b0;
      end

      // read port, always open
      case (RD_ADDR)
         SCC_ADDR_STBY: next_r.rd = r.stby;
         SCC_ADDR_CSTAT: next_r.rd = cstat;
         SCC_ADDR_OSC_SETTLE_SELECT: next_r.rd = r.osc_settle_select;
         default: next_r.rd = 8'h00;
      endcase
   end

   // ==========================================================
   // register
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         r <= '0;
         r.mode <= SCC_RUN;
         r.stby <= SCC_RST_STBY;
         r.osc_settle_select <= SCC_RST_OSC_SETTLE_SELECT;
         r.main_run <= 1'b1;
         r.xtal <= 1'b1;
         r.sub_run <= 1'b1;
         r.active <= 1'b1;
         r.on_sub <= SCC_RST_CSTAT[SCC_B_CPU_SRC];
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from flops
   assign RD_DATA = r.rd;
   assign CPU_TICK = r.tick;
   assign CPU_ON_SUB = r.on_sub;
   assign SYS_ACTIVE = r.active;
   assign MAIN_OSC_RUN = r.main_run;
   assign XTAL_AMP_EN = r.xtal;
   assign SUB_OSC_RUN = r.sub_run;
   assign OPERR_IRQ = r.operr;
   assign OPERR_PC = r.pc;
   assign MODE = r.mode;

   // ==========================================================
   // assertions
   property p_bad_guard;
      @(posedge SYS_CLK) disable iff (!NRST)
      (GWR.valid && !guard_ok && r.mode == SCC_RUN) |=> (r.stby[7:2] == $past(r.stby[7:2])) && r.operr;
   endproperty
   a_bad_guard: assert property (p_bad_guard) else $error("bad guard wrote or no error");

   property p_good_guard;
      @(posedge SYS_CLK) disable iff (!NRST)
      (GWR.valid && guard_ok && r.mode == SCC_RUN) |=> (r.stby[7:2] == ($past(GWR.data[7:2]) & 6'h3d)) && !r.operr;
   endproperty
   a_good_guard: assert property (p_good_guard) else $error("guarded write lost");

   property p_plain_ignored;
      @(posedge SYS_CLK) disable iff (!NRST)
      (WR.valid && WR.addr == SCC_ADDR_STBY && !GWR.valid) |=> (r.stby[7:2] == $past(r.stby[7:2])) && !r.operr;
   endproperty
   a_plain_ignored: assert property (p_plain_ignored) else $error("plain write changed control");

   property p_ret_pc;
      @(posedge SYS_CLK) disable iff (!NRST)
      r.operr |-> (r.pc == $past(GWR.pc));
   endproperty
   a_ret_pc: assert property (p_ret_pc) else $error("wrong error return address");

   property p_cstat_read;
      @(posedge SYS_CLK) disable iff (!NRST)
      (RD_ADDR == SCC_ADDR_CSTAT) |=> RD_DATA[1] && (RD_DATA[0] == $past(r.on_sub)) && !RD_DATA[3]
         && (RD_DATA[7:4] == $past(r.stby[7:4]));
   endproperty
   a_cstat_read: assert property (p_cstat_read) else $error("status read wrong");

   property p_halt_gate;
      @(posedge SYS_CLK) disable iff (!NRST)
      (r.mode == SCC_HALT) [*2] |-> !CPU_TICK && SYS_ACTIVE;
   endproperty
   a_halt_gate: assert property (p_halt_gate) else $error("cpu clocked in halt");

   property p_main_keep;
      @(posedge SYS_CLK) disable iff (!NRST)
      (!r.stby[SCC_B_CK_HI] && r.mode != SCC_STOP) |-> MAIN_OSC_RUN;
   endproperty
   a_main_keep: assert property (p_main_keep) else $error("main osc stopped on main clock");

   property p_halt_hold;
      @(posedge SYS_CLK) disable iff (!NRST)
      (r.mode == SCC_HALT && !wake && !MACRO_REQ) |=> (r.mode == SCC_HALT);
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("halt left without source");

   property p_settle_gate;
      @(posedge SYS_CLK) disable iff (!NRST)
      (r.mode == SCC_SETTLE) |-> !CPU_TICK ##0 (settle_busy || settle_done || r.settle_go);
   endproperty
   a_settle_gate: assert property (p_settle_gate) else $error("cpu ran before settle");

   property p_macro_back;
      @(posedge SYS_CLK) disable iff (!NRST)
      (r.mode == SCC_MACRO && MACRO_DONE) |=> (r.mode == SCC_HALT);
   endproperty
   a_macro_back: assert property (p_macro_back) else $error("macro did not return to halt");

   // main scenarios
   c_stop_wake: cover property (@(posedge SYS_CLK) disable iff (!NRST) r.mode == SCC_SETTLE ##1 r.mode == SCC_RUN);
   c_macro: cover property (@(posedge SYS_CLK) disable iff (!NRST) r.mode == SCC_MACRO ##1 r.mode == SCC_HALT);
   c_operr: cover property (@(posedge SYS_CLK) disable iff (!NRST) r.operr);
endmodule : scc_top

//--- sim/scc_cpu_model.sv
// scc_cpu_model: cpu core side, issues guarded writes, ordinary writes and reads
// assumes one caller process; every change is made on a falling clock edge
`timescale 1ns/1ps
module scc_cpu_model (
   input logic clk, // system clock
   input logic [7:0] rd_data, // read data from the block
   output scc_pkg::scc_gwr_t gwr, // guarded immediate write
   output scc_pkg::scc_wr_t wr, // ordinary data write
   output logic [15:0] rd_addr // read address
);
   import scc_pkg::*;
   // ==========================================================
   // idle bus at time zero
   initial begin
      gwr = '0;
      wr = '0;
      rd_addr = 16'h0000;
   end
   // ==========================================================
   // guarded write; bad pair imitates a runaway program
   task automatic guarded(input logic [7:0] data, input logic bad, input logic [19:0] pc);
      @(negedge clk);
      gwr.valid = 1'b1;
      gwr.op3 = 8'ha5;
      gwr.op4 = bad ? 8'h5b : 8'h5a; // complementary pair unless bad
      gwr.data = data;
      gwr.pc = pc;
      @(negedge clk);
      gwr = {1'b0, ~gwr[43:0]}; // released fields show inverse, not stale value
      repeat (3) @(negedge clk); // three idle slots after a standby write
   endtask : guarded
   // ordinary one-byte write
   task automatic write(input logic [15:0] a, input logic [7:0] data);
      @(negedge clk);
      wr.valid = 1'b1;
      wr.addr = a;
      wr.data = data;
      @(negedge clk);
      wr = {1'b0, ~wr[23:0]}; // released fields inverted
   endtask : write
   // read: data is registered one cycle after the address
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk);
      rd_addr = a;
      @(negedge clk);
      d = rd_data;
   endtask : rd
endmodule : scc_cpu_model

//--- sim/scc_top_test.sv
// scc_top_test: self-checking bench for the standby and clock control block
// assumes scc_cpu_model on the register side; stimulus changes on falling edges
`timescale 1ns/1ps
module scc_top_test;
   import scc_pkg::*;
   // ==========================================================
   // table of clock select cases
   typedef struct packed {
      logic [7:0] data; // guarded write value
      logic [7:0] stby; // expected standby_control
      logic [7:0] cstat; // expected clock_status
      logic [2:0] outs; // on_sub, main run, sub run
      logic [4:0] ticks; // cpu ticks in 16 cycles
   } scc_row_t;
   localparam scc_row_t ROWS [6] = '{
      '{8'h00, 8'h00, 8'h02, 3'h3, 5'h10},
      '{8'h14, 8'h14, 8'h16, 3'h3, 5'h08},
      '{8'h28, 8'h20, 8'h22, 3'h3, 5'h04},
      '{8'hb0, 8'hb0, 8'hb2, 3'h2, 5'h02},
      '{8'h74, 8'h74, 8'h77, 3'h5, 5'h04},
      '{8'hc0, 8'hc0, 8'hc3, 3'h6, 5'h04}};
   logic clk = 1'b0; // 200 MHz
   logic nrst = 1'b0; // reset, active low
   logic nmi = 1'b0, irq = 1'b0, mreq = 1'b0, mdone = 1'b0, sub_tick = 1'b0;
   logic [1:0] sc = 2'h0; // sub clock prescaler, tick every 4 cycles
   scc_gwr_t gwr;
   scc_wr_t wr;
   logic [15:0] rd_addr;
   logic [7:0] rd_data, d;
   logic cpu_tick, on_sub, sys_act, main_run, xtal_en, sub_run, operr;
   logic [19:0] operr_pc, n;
   scc_mode_t mode;
   int n_mismatch = 0, samples_checked = 0, n_err = 0;
   scc_top #(.SETTLE_LOG_MAX(10)) scc_top_inst (.SYS_CLK(clk), .NRST(nrst), .GWR(gwr), .WR(wr),
      .RD_ADDR(rd_addr), .NMI_PIN(nmi), .IRQ_UNMASKED(irq), .MACRO_REQ(mreq), .MACRO_DONE(mdone),
      .SUB_TICK(sub_tick), .RD_DATA(rd_data), .CPU_TICK(cpu_tick), .CPU_ON_SUB(on_sub),
      .SYS_ACTIVE(sys_act), .MAIN_OSC_RUN(main_run), .XTAL_AMP_EN(xtal_en), .SUB_OSC_RUN(sub_run),
      .OPERR_IRQ(operr), .OPERR_PC(operr_pc), .MODE(mode));
   scc_cpu_model scc_cpu_model_inst (.clk(clk), .rd_data(rd_data), .gwr(gwr), .wr(wr), .rd_addr(rd_addr));
   // ==========================================================
   // clock, sub clock ticks and error pulse monitor
   always #2.5 clk = ~clk;
   always @(negedge clk) begin
      sc <= sc + 2'h1;
      sub_tick <= (sc == 2'h3);
      if (operr === 1'b1) n_err++; // one-cycle pulse counts once
   end
   // ==========================================================
   // comparison, verdict, watchdog
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   initial begin
      #200000;
      n_mismatch++; // a hang counts as a mismatch
      print_verdict();
   end
   // ==========================================================
   // helpers
   task automatic reset_check();
      scc_cpu_model_inst.rd(SCC_ADDR_STBY, d);
      check(d, 8'h30);
      scc_cpu_model_inst.rd(SCC_ADDR_CSTAT, d);
      check(d, 8'h32);
      scc_cpu_model_inst.rd(SCC_ADDR_OSC_SETTLE_SELECT, d);
      check(d, 8'h00);
      check({mode, operr_pc, main_run, xtal_en, sub_run, sys_act, on_sub}, 32'h1e);
   endtask : reset_check
   // release stop by nmi, time the settle wait with cpu held
   task automatic stop_release(input logic [19:0] target);
      logic [19:0] t;
      t = 20'h0;
      n = 20'h0;
      @(negedge clk);
      nmi = 1'b1;
      @(negedge clk);
      nmi = 1'b0;
      check(mode, SCC_SETTLE);
      while (mode !== SCC_RUN && n < 20'h800) begin
         t += cpu_tick;
         n++;
         @(negedge clk);
      end
      check(t, 0);
      check(n >= target && n <= target + 4, 1);
      scc_cpu_model_inst.rd(SCC_ADDR_STBY, d);
      check(d, 8'h30);
   endtask : stop_release
   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      reset_check();
      // clock select rows; bit 3 write-ignored, top code bit picks sub clock
      for (int i = 0; i < 6; i++) begin
         scc_cpu_model_inst.guarded(ROWS[i].data, 1'b0, 20'h00100);
         scc_cpu_model_inst.rd(SCC_ADDR_STBY, d);
         check(d, ROWS[i].stby);
         scc_cpu_model_inst.rd(SCC_ADDR_CSTAT, d);
         check(d, ROWS[i].cstat);
         check({on_sub, main_run, sub_run}, ROWS[i].outs);
         n = 20'h0;
         repeat (16) begin
            @(negedge clk);
            n += cpu_tick;
         end
         check(n, ROWS[i].ticks);
      end
      scc_cpu_model_inst.guarded(8'h30, 1'b0, 20'h00104);
      // bad complement: no write, error with faulting address
      scc_cpu_model_inst.guarded(8'h31, 1'b1, 20'h12345);
      check(n_err, 1);
      check(operr_pc, 20'h12345);
      scc_cpu_model_inst.rd(SCC_ADDR_STBY, d);
      check({mode, d}, {SCC_RUN, 8'h30});
      // ordinary writes to control and status are ignored silently
      scc_cpu_model_inst.write(SCC_ADDR_STBY, 8'h31);
      scc_cpu_model_inst.write(SCC_ADDR_CSTAT, 8'hff);
      scc_cpu_model_inst.write(SCC_ADDR_OSC_SETTLE_SELECT, 8'hff);
      scc_cpu_model_inst.rd(SCC_ADDR_STBY, d);
      check({mode, d, n_err[3:0]}, {SCC_RUN, 8'h30, 4'h1});
      scc_cpu_model_inst.rd(SCC_ADDR_CSTAT, d);
      check(d, 8'h32);
      scc_cpu_model_inst.rd(SCC_ADDR_OSC_SETTLE_SELECT, d);
      check(d, 8'h87);
      check({main_run, xtal_en}, 2'h2);
      scc_cpu_model_inst.rd(16'hffc1, d);
      check(d, 8'h00);
      scc_cpu_model_inst.write(SCC_ADDR_OSC_SETTLE_SELECT, 8'h07);
      // halt, macro service and return to halt, release by interrupt
      scc_cpu_model_inst.guarded(8'h31, 1'b0, 20'h00200);
      n = 20'h0;
      repeat (8) begin
         @(negedge clk);
         n += cpu_tick;
      end
      check({mode, sys_act, n}, {SCC_HALT, 1'b1, 20'h0});
      mreq = 1'b1;
      @(negedge clk);
      mreq = 1'b0;
      check(mode, SCC_MACRO);
      mdone = 1'b1;
      @(negedge clk);
      mdone = 1'b0;
      check(mode, SCC_HALT);
      irq = 1'b1;
      @(negedge clk);
      irq = 1'b0;
      check(mode, SCC_RUN);
      scc_cpu_model_inst.rd(SCC_ADDR_STBY, d);
      check(d, 8'h30);
      // idle keeps the oscillator, stops the rest
      scc_cpu_model_inst.guarded(8'h33, 1'b0, 20'h00300);
      check({mode, sys_act, main_run}, {SCC_IDLE, 2'h1});
      nmi = 1'b1;
      @(negedge clk);
      nmi = 1'b0;
      check(mode, SCC_RUN);
      // wake pending as halt is written: request dropped
      irq = 1'b1;
      scc_cpu_model_inst.guarded(8'h31, 1'b0, 20'h00400);
      irq = 1'b0;
      scc_cpu_model_inst.rd(SCC_ADDR_STBY, d);
      check({mode, d}, {SCC_RUN, 8'h30});
      // stop with shortest crystal wait, 2**(10-7) cycles
      scc_cpu_model_inst.guarded(8'h32, 1'b0, 20'h00500);
      check({mode, sys_act, main_run}, {SCC_STOP, 2'h0});
      stop_release(20'h8);
      // external clock chosen before stop, fixed 512 cycle wait
      scc_cpu_model_inst.write(SCC_ADDR_OSC_SETTLE_SELECT, 8'h80);
      scc_cpu_model_inst.guarded(8'h32, 1'b0, 20'h00600);
      stop_release(20'h200);
      // second reset in mid-run restores every register
      scc_cpu_model_inst.guarded(8'h74, 1'b0, 20'h00700);
      @(negedge clk);
      nrst = 1'b0;
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      reset_check();
      print_verdict();
   end
endmodule : scc_top_test
